// [core_exec_cfg.svh]
// Operation
// - Watchdog kick clears the watchdog counter and its prescaler.
// - Watchdog kick sets the expired flag and the sleep-entered flag.
// - Call pushes the next instruction address onto the return stack head.
// - Call loads literal into pc[10:0] and latch bits 4:3 into pc[12:11].
// - Call takes any 11-bit target, two cycles, no status flag change.
// - Invert file register; destination bit picks accumulator or register; updates zero.
// - Zero file register writes zero and sets the zero flag.
// - Decrement file register into the chosen destination; updates zero.
// - Zero accumulator writes zero to accumulator and sets the zero flag.
// - Decrement-skip stores result by destination bit, touches no status flag.
// - Decrement-skip with zero result discards the next instruction, two cycles.
`ifndef CORE_EXEC_CFG_SVH
`define CORE_EXEC_CFG_SVH

`define STACK_DEPTH_DEF 8
`define FILE_DEPTH_DEF  128

`define PC_RST     13'h0000
`define ACC_RST    8'h00
`define ZERO_RST   1'b0
`define EXP_RST    1'b1
`define SLEEP_RST  1'b1
`define RDATA_RST  8'h00
`define STACK_RST  13'h0000

`define PC_STEP    13'h0001
`define DEC_STEP   8'h01
`define BYTE_ZERO  8'h00

`define DEST_BIT   7
`define FADDR_MSB  6
`define LIT_MSB    10
`define LATCH_HI   4
`define LATCH_LO   3

`define OPM_KICK   14'h3FFF
`define OPV_KICK   14'h0064
`define OPM_CALL   14'h3800
`define OPV_CALL   14'h2000
`define OPM_FILE   14'h3F00
`define OPV_INV    14'h0900
`define OPV_DEC    14'h0300
`define OPV_DSKIP  14'h0B00
`define OPM_CLR    14'h3F80
`define OPV_ZREG   14'h0180
`define OPV_ZACC   14'h0100

`endif

// [core_exec_pkg.sv]
package core_exec_pkg;

  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } fsm_t;

  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_KICK  = 3'b001,
    OP_CALL  = 3'b010,
    OP_INV   = 3'b011,
    OP_ZREG  = 3'b100,
    OP_DEC   = 3'b101,
    OP_ZACC  = 3'b110,
    OP_DSKIP = 3'b111
  } op_t;

  typedef struct packed {
    logic zero;
    logic expired;
    logic sleep;
  } status_t;

  typedef struct packed {
    fsm_t        fsm;
    logic        skip_adv;
    logic [12:0] pc;
    logic [7:0]  acc;
    status_t     st;
    logic        wdt_clr;
    logic        pre_clr;
    logic [7:0]  rdata;
  } core_state_t;

  typedef struct packed {
    logic [12:0] head;
  } stack_state_t;

endpackage

// [return_stack.sv]
`timescale 1ns/10ps
`include "core_exec_cfg.svh"

module return_stack import core_exec_pkg::*; #(
  parameter int DEPTH = `STACK_DEPTH_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        push,
  input  wire logic [12:0] push_addr,
  output logic      [12:0] stack_head
);
  localparam int PW = $clog2(DEPTH);

  // Circular: a push past the last level overwrites the oldest entry
  logic [12:0]   slot [DEPTH];
  logic [PW-1:0] ptr_ff;
  stack_state_t  cur_ff;
  stack_state_t  nxt_st;

  always_comb begin
    nxt_st = cur_ff;
    if (push) begin
      nxt_st.head = push_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '{head: `STACK_RST};
      ptr_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
      if (push) begin
        ptr_ff <= ptr_ff + PW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      slot[ptr_ff + PW'(1)] <= push_addr;
    end
  end

  assign stack_head = cur_ff.head;
endmodule

// [core_exec.sv]
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "core_exec_cfg.svh"

module core_exec import core_exec_pkg::*; #(
  parameter int STACK_DEPTH = `STACK_DEPTH_DEF,
  parameter int FILE_DEPTH  = `FILE_DEPTH_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  input  wire logic [4:0]  upper_pc_latch,
  input  wire logic        wdt_timeout_evt,
  input  wire logic        sleep_evt,
  input  wire logic [6:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic      [12:0] pc,
  output logic      [7:0]  accumulator,
  output status_t          status,
  output logic      [12:0] stack_head,
  output logic             instr_discard,
  output logic             wdt_clear,
  output logic             prescaler_clear
);

  core_state_t cur_ff;
  core_state_t nxt_st;

  // File registers carry no reset, as in the core they model
  logic [7:0] file_mem [FILE_DEPTH];

  op_t         op;
  logic        exec_now;
  logic [6:0]  faddr;
  logic        dest_reg;
  logic [7:0]  fval;
  logic [7:0]  res;
  logic        res_wr;
  logic        file_we;
  logic [6:0]  file_wa;
  logic [7:0]  file_wd;
  logic        push;
  logic [12:0] push_addr;

  function automatic op_t decode(input logic [13:0] w);
    op_t o;
    o = OP_OTHER;
    if ((w & `OPM_KICK) == `OPV_KICK) begin
      o = OP_KICK;
    end else if ((w & `OPM_CALL) == `OPV_CALL) begin
      o = OP_CALL;
    end else if ((w & `OPM_FILE) == `OPV_INV) begin
      o = OP_INV;
    end else if ((w & `OPM_FILE) == `OPV_DEC) begin
      o = OP_DEC;
    end else if ((w & `OPM_FILE) == `OPV_DSKIP) begin
      o = OP_DSKIP;
    end else if ((w & `OPM_CLR) == `OPV_ZREG) begin
      o = OP_ZREG;
    end else if ((w & `OPM_CLR) == `OPV_ZACC) begin
      o = OP_ZACC;
    end
    return o;
  endfunction

  assign op       = decode(instr_word);
  assign exec_now = instr_valid && (cur_ff.fsm == ST_EXEC);
  assign faddr    = instr_word[`FADDR_MSB:0];
  assign dest_reg = instr_word[`DEST_BIT];
  assign fval     = file_mem[faddr];

  always_comb begin
    nxt_st         = cur_ff;
    nxt_st.wdt_clr = 1'b0;
    nxt_st.pre_clr = 1'b0;
    nxt_st.rdata   = `RDATA_RST;
    res            = `BYTE_ZERO;
    res_wr         = 1'b0;
    file_we        = 1'b0;
    file_wa        = faddr;
    file_wd        = `BYTE_ZERO;
    push           = 1'b0;
    push_addr      = cur_ff.pc + `PC_STEP;
    // Outside events clear the flags; a kick in the same cycle wins below
    if (wdt_timeout_evt) begin
      nxt_st.st.expired = 1'b0;
    end
    if (sleep_evt) begin
      nxt_st.st.sleep = 1'b0;
    end
    if (instr_valid) begin
      case (cur_ff.fsm)
        ST_FLUSH: begin
          // Discarded slot runs as a no-operation
          if (cur_ff.skip_adv) begin
            nxt_st.pc = cur_ff.pc + `PC_STEP;
          end
          nxt_st.fsm = ST_EXEC;
        end
        default: begin
          nxt_st.pc = cur_ff.pc + `PC_STEP;
          case (op)
            OP_KICK: begin
              nxt_st.wdt_clr    = 1'b1;
              nxt_st.pre_clr    = 1'b1;
              nxt_st.st.expired = 1'b1;
              nxt_st.st.sleep   = 1'b1;
            end
            OP_CALL: begin
              push     = 1'b1;
              nxt_st.pc = {upper_pc_latch[`LATCH_HI:`LATCH_LO],
                           instr_word[`LIT_MSB:0]};
              // Second cycle flushes the stale fetch; pc holds at target
              nxt_st.fsm      = ST_FLUSH;
              nxt_st.skip_adv = 1'b0;
            end
            OP_INV: begin
              res            = ~fval;
              res_wr         = 1'b1;
              nxt_st.st.zero = (res == `BYTE_ZERO);
            end
            OP_ZREG: begin
              file_we        = 1'b1;
              file_wd        = `BYTE_ZERO;
              nxt_st.st.zero = 1'b1;
            end
            OP_DEC: begin
              res            = fval - `DEC_STEP;
              res_wr         = 1'b1;
              nxt_st.st.zero = (res == `BYTE_ZERO);
            end
            OP_ZACC: begin
              nxt_st.acc     = `BYTE_ZERO;
              nxt_st.st.zero = 1'b1;
            end
            OP_DSKIP: begin
              res    = fval - `DEC_STEP;
              res_wr = 1'b1;
              if (res == `BYTE_ZERO) begin
                nxt_st.fsm      = ST_FLUSH;
                nxt_st.skip_adv = 1'b1;
              end
            end
            default: begin
            end
          endcase
          if (res_wr) begin
            if (dest_reg) begin
              file_we = 1'b1;
              file_wd = res;
            end else begin
              nxt_st.acc = res;
            end
          end
        end
      endcase
    end
    // Bus write yields to an instruction write in the same cycle
    if (bus_wr && !file_we) begin
      file_we = 1'b1;
      file_wa = bus_addr;
      file_wd = bus_wdata;
    end
    if (bus_rd) begin
      nxt_st.rdata = file_mem[bus_addr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '{fsm: ST_EXEC, skip_adv: 1'b0, pc: `PC_RST, acc: `ACC_RST,
                 st: '{zero: `ZERO_RST, expired: `EXP_RST, sleep: `SLEEP_RST},
                 wdt_clr: 1'b0, pre_clr: 1'b0, rdata: `RDATA_RST};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  always_ff @(posedge core_clk) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  return_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .push       (push),
    .push_addr  (push_addr),
    .stack_head (stack_head)
  );

  assign bus_rdata       = cur_ff.rdata;
  assign pc              = cur_ff.pc;
  assign accumulator     = cur_ff.acc;
  assign status          = cur_ff.st;
  assign instr_discard   = cur_ff.fsm == ST_FLUSH;
  assign wdt_clear       = cur_ff.wdt_clr;
  assign prescaler_clear = cur_ff.pre_clr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic kick_now;
  logic call_now;
  logic inv_acc;
  logic dec_acc;
  logic skip_now;
  assign kick_now = exec_now && (op == OP_KICK);
  assign call_now = exec_now && (op == OP_CALL);
  assign inv_acc  = exec_now && (op == OP_INV) && !dest_reg;
  assign dec_acc  = exec_now && (op == OP_DEC) && !dest_reg;
  assign skip_now = exec_now && (op == OP_DSKIP);

  AST_KICK_CLEAR: assert property (kick_now |=> wdt_clear && prescaler_clear ##1
                                   !wdt_clear || $past(kick_now))
    else $error("watchdog clear pulses missing after kick");
  AST_KICK_FLAGS: assert property (kick_now |=> status.expired && status.sleep)
    else $error("kick did not set expired and sleep flags");
  AST_CALL_PUSH: assert property (call_now |=> stack_head == $past(pc) + `PC_STEP)
    else $error("call pushed wrong return address");
  AST_CALL_TARGET: assert property (call_now |=> pc == {$past(upper_pc_latch[4:3]),
                                    $past(instr_word[10:0])})
    else $error("call loaded wrong target");
  AST_CALL_TWO: assert property (call_now |=> instr_discard && $stable(status.zero)
                                 ##1 !instr_discard || !$past(instr_valid))
    else $error("call is not a two-cycle flag-neutral instruction");
  AST_INVERT: assert property (inv_acc |=> accumulator == ~$past(fval)
                               && status.zero == (accumulator == 8'h00))
    else $error("invert result or zero flag wrong");
  AST_ZERO_REG: assert property (exec_now && op == OP_ZREG |=> status.zero
                                 && file_mem[$past(faddr)] == 8'h00)
    else $error("zero file register failed");
  AST_DEC: assert property (dec_acc |=> accumulator == $past(fval) - `DEC_STEP
                            && status.zero == (accumulator == 8'h00))
    else $error("decrement result or zero flag wrong");
  AST_ZERO_ACC: assert property (exec_now && op == OP_ZACC |=>
                                 accumulator == 8'h00 && status.zero)
    else $error("zero accumulator failed");
  AST_SKIP_FLAGS: assert property (skip_now |=> $stable(status.zero))
    else $error("decrement-skip touched zero flag");
  AST_SKIP: assert property (skip_now |=> instr_discard == ($past(fval) == 8'h01))
    else $error("decrement-skip discard decision wrong");
  AST_ZERO_RULE: assert property (exec_now && op == OP_DEC && dest_reg |=>
                                  status.zero == ($past(fval) == 8'h01))
    else $error("zero flag does not track result");

  COV_CALL: cover property (call_now ##1 instr_discard ##1 exec_now);
  COV_SKIP: cover property (skip_now && fval == 8'h01 ##1 instr_discard);
  COV_KICK: cover property (kick_now ##1 status.expired);
  COV_NOSKIP: cover property (skip_now && fval != 8'h01 ##1 !instr_discard);
  COV_CALL_TOP: cover property (call_now && instr_word[`LIT_MSB:0] == 11'h7ff);

  // Destination, flush-slot, status, pc-step and watchdog-pulse checks
  logic inv_reg;
  logic dec_reg;
  logic flush_now;
  logic quiet_evt;
  assign inv_reg   = exec_now && (op == OP_INV) && dest_reg;
  assign dec_reg   = exec_now && (op == OP_DEC) && dest_reg;
  assign flush_now = instr_valid && (cur_ff.fsm == ST_FLUSH);
  assign quiet_evt = !wdt_timeout_evt && !sleep_evt;

  AST_INV_REG: assert property (inv_reg |=>
                                file_mem[$past(faddr)] == ~$past(fval)
                                && $stable(accumulator)
                                && status.zero == ($past(fval) == 8'hff))
    else $error("invert to register wrong");
  AST_DEC_REG: assert property (dec_reg |=>
                                file_mem[$past(faddr)] == $past(fval) - `DEC_STEP
                                && $stable(accumulator))
    else $error("decrement to register wrong");
  AST_ZREG_KEEP: assert property (exec_now && op == OP_ZREG |=>
                                  $stable(accumulator))
    else $error("zero file register touched accumulator");
  AST_SKIP_DEST: assert property (skip_now && dest_reg |=>
                                  file_mem[$past(faddr)] == $past(fval) - `DEC_STEP
                                  && $stable(accumulator))
    else $error("decrement-skip register result wrong");
  AST_SKIP_ACC: assert property (skip_now && !dest_reg |=>
                                 accumulator == $past(fval) - `DEC_STEP)
    else $error("decrement-skip accumulator result wrong");
  AST_SKIP_STATUS: assert property (skip_now && quiet_evt |=>
                                    $stable(status))
    else $error("decrement-skip changed a status flag");
  AST_CALL_FLAGS: assert property (call_now && quiet_evt |=>
                                   $stable(status))
    else $error("call changed a status flag");
  AST_CALL_HOLD: assert property (call_now ##1 flush_now |=>
                                  pc == $past(pc) && !instr_discard)
    else $error("pc moved during call flush slot");
  AST_SKIP_ADV: assert property (skip_now && fval == 8'h01 ##1 flush_now |=>
                                 pc == $past(pc) + `PC_STEP
                                 && !instr_discard)
    else $error("skipped slot did not advance pc");
  AST_FLUSH_NOP: assert property (flush_now |=>
                                  $stable(accumulator) && $stable(stack_head))
    else $error("flush slot was not a no-operation");
  AST_PC_STEP: assert property (exec_now && op != OP_CALL |=>
                                pc == $past(pc) + `PC_STEP)
    else $error("pc did not step after instruction");
  AST_KICK_PULSE: assert property (!kick_now |=>
                                   !wdt_clear && !prescaler_clear)
    else $error("watchdog clear pulse without kick");
  AST_EVT_CLEAR: assert property (wdt_timeout_evt && !kick_now |=>
                                  !status.expired)
    else $error("timeout event did not clear expired flag");
endmodule

// [test_core_instruction_execute_subset.sv]
`timescale 1ns/10ps
`include "core_exec_cfg.svh"

module test_core_instruction_execute_subset import core_exec_pkg::*; ;
  logic        core_clk, rst_n, instr_valid, wdt_timeout_evt, sleep_evt, bus_wr, bus_rd;
  logic [13:0] instr_word, w;
  logic [4:0]  upper_pc_latch;
  logic [6:0]  bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, accumulator, acc_m;
  logic [12:0] pc, stack_head, pc_m, head_m;
  status_t     status;
  logic        instr_discard, wdt_clear, prescaler_clear, z_m, exp_m, slp_m;
  logic [7:0]  mem_m [128];
  logic [13:0] base [7] = '{`OPV_KICK, `OPV_CALL, `OPV_INV, `OPV_DEC, `OPV_DSKIP, `OPV_ZREG,
                            `OPV_ZACC};
  logic [13:0] lowm [7] = '{14'h0000, 14'h07ff, 14'h00ff, 14'h00ff, 14'h00ff, 14'h007f,
                            14'h0000};
  int          n_mismatch, checked, sel;

  core_exec dut_u (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .instr_valid     (instr_valid),
    .instr_word      (instr_word),
    .upper_pc_latch  (upper_pc_latch),
    .wdt_timeout_evt (wdt_timeout_evt),
    .sleep_evt       (sleep_evt),
    .bus_addr        (bus_addr),
    .bus_wdata       (bus_wdata),
    .bus_wr          (bus_wr),
    .bus_rd          (bus_rd),
    .bus_rdata       (bus_rdata),
    .pc              (pc),
    .accumulator     (accumulator),
    .status          (status),
    .stack_head      (stack_head),
    .instr_discard   (instr_discard),
    .wdt_clear       (wdt_clear),
    .prescaler_clear (prescaler_clear)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk_w(string what, logic [12:0] exp, logic [12:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge core_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    mem_m[a] = d;
  endtask

  task automatic rd(logic [6:0] a);
    @(posedge core_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    chk_w("bus_rdata", {5'h00, mem_m[a]}, {5'h00, bus_rdata});
    @(negedge core_clk);
    chk_w("bus_rdata idle", 13'h0000, {5'h00, bus_rdata});
  endtask

  task automatic put(logic d, logic [6:0] f, logic [7:0] r);
    if (d) begin
      mem_m[f] = r;
    end else begin
      acc_m = r;
    end
  endtask

  // Model first, then drive; flush slot carries a random word that must not act
  task automatic issue(logic [13:0] wd, logic [4:0] lat, logic ev);
    logic [7:0] r;
    logic       fl, kick, call;
    fl = 1'b0;
    kick = (wd == `OPV_KICK);
    call = ((wd & `OPM_CALL) == `OPV_CALL);
    r = mem_m[wd[6:0]] - 8'h01;
    if (call) begin
      head_m = pc_m + 13'h0001;
      pc_m = {lat[4:3], wd[10:0]};
      fl = 1'b1;
    end else begin
      pc_m = pc_m + 13'h0001;
      case (wd & `OPM_FILE)
        `OPV_INV: begin
          r = ~mem_m[wd[6:0]];
          put(wd[7], wd[6:0], r);
          z_m = (r == 8'h00);
        end
        `OPV_DEC: begin
          put(wd[7], wd[6:0], r);
          z_m = (r == 8'h00);
        end
        `OPV_DSKIP: begin
          put(wd[7], wd[6:0], r);
          fl = (r == 8'h00);
        end
        default: begin
          if ((wd & `OPM_CLR) == `OPV_ZREG) mem_m[wd[6:0]] = 8'h00;
          if ((wd & `OPM_CLR) == `OPV_ZACC) acc_m = 8'h00;
          if (!kick) z_m = 1'b1;
        end
      endcase
    end
    if (kick) begin
      exp_m = 1'b1;
      slp_m = 1'b1;
    end else if (ev) begin
      exp_m = 1'b0;
      slp_m = 1'b0;
    end
    @(posedge core_clk);
    instr_valid     <= 1'b1;
    instr_word      <= wd;
    upper_pc_latch  <= lat;
    wdt_timeout_evt <= ev;
    sleep_evt       <= ev;
    @(posedge core_clk);
    instr_valid     <= fl;
    instr_word      <= 14'($urandom);
    wdt_timeout_evt <= 1'b0;
    sleep_evt       <= 1'b0;
    @(negedge core_clk);
    chk_w("pc", pc_m, pc);
    chk_w("accumulator", {5'h00, acc_m}, {5'h00, accumulator});
    chk_w("stack_head", head_m, stack_head);
    chk_b("zero", z_m, status.zero);
    chk_b("expired", exp_m, status.expired);
    chk_b("sleep", slp_m, status.sleep);
    chk_b("wdt_clear", kick, wdt_clear);
    chk_b("prescaler_clear", kick, prescaler_clear);
    chk_b("instr_discard", fl, instr_discard);
    if (fl) begin
      if (!call) pc_m = pc_m + 13'h0001;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      @(negedge core_clk);
      chk_w("pc after flush", pc_m, pc);
      chk_w("acc after flush", {5'h00, acc_m}, {5'h00, accumulator});
      chk_b("discard end", 1'b0, instr_discard);
    end
    if (!call && !kick) rd(wd[6:0]);
  endtask

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    upper_pc_latch = 5'h00;
    wdt_timeout_evt = 1'b0;
    sleep_evt = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 7'h00;
    bus_wdata = 8'h00;
    pc_m = 13'h0000;
    head_m = 13'h0000;
    acc_m = 8'h00;
    z_m = 1'b0;
    exp_m = 1'b1;
    slp_m = 1'b1;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h511d));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk_w("reset pc", 13'h0000, pc);
    chk_w("reset stack_head", 13'h0000, stack_head);
    chk_w("reset status", 13'h0003, {10'h000, status});
    $display("test reset done");
    for (int i = 0; i < 128; i++) wr(7'(i), 8'($urandom));
    wr(7'h01, 8'h01);
    wr(7'h02, 8'h00);
    wr(7'h03, 8'hff);
    $display("test preload done");
    issue(`OPV_ZACC, 5'h00, 1'b1);
    issue(`OPV_KICK, 5'h00, 1'b1);
    issue(`OPV_DSKIP | 14'h0081, 5'h00, 1'b0);
    issue(`OPV_DSKIP | 14'h0001, 5'h00, 1'b0);
    issue(`OPV_DEC | 14'h0082, 5'h00, 1'b0);
    issue(`OPV_INV | 14'h0003, 5'h00, 1'b0);
    issue(`OPV_ZREG | 14'h007f, 5'h00, 1'b0);
    issue(`OPV_CALL | 14'h07ff, 5'h18, 1'b0);
    issue(`OPV_CALL, 5'h07, 1'b0);
    $display("test corner ops done");
    for (int i = 0; i < 300; i++) begin
      sel = $urandom_range(6);
      w = base[sel] | (14'($urandom) & lowm[sel]);
      // Seed some skips, a plain random byte rarely decrements to zero
      if (sel == 4 && $urandom_range(3) == 0) wr(w[6:0], 8'h01);
      issue(w, 5'($urandom), ($urandom_range(7) == 0));
    end
    $display("test random ops done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
